// File: hw/hsfs_top.sv
// Hot-swap fault supervisor: limit/breaker/retry sequencing, lockouts and status port
`timescale 1ns/1ps
`default_nettype none

module hsfs_top #(
  parameter logic [6:0] DEV_ADDR = 7'h40  // Bus address, arbitrary default
) (
  input  wire logic MCLK,
  input  wire logic RST_N,
  input  wire logic LIMIT_SELECT_PIN,
  input  wire logic BREAKER_SELECT_PIN,
  input  wire logic RETRY_PIN,
  input  wire logic UNDERVOLT_ENABLE_PIN,
  input  wire logic OVERVOLT_PIN,
  input  wire logic GOOD_SENSE_IN,
  input  wire logic SENSE_OVER_25MV,
  input  wire logic SENSE_OVER_46MV,
  input  wire logic BREAKER_OVER_1X8,
  input  wire logic BREAKER_OVER_3X6,
  input  wire logic POWER_LIMIT_CMP,
  input  wire logic TIMER_ABOVE_1V7,
  input  wire logic TIMER_ABOVE_1V0,
  input  wire logic TIMER_ABOVE_0V3,
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE,
  output logic      SMBA_O,
  output logic      SMBA_OE,
  output logic      GATE_STRONG_PD,
  output logic      GATE_PD_2MA,
  output logic      GATE_CHARGE,
  output logic      GATE_REGULATE,
  output logic      TIMER_SRC_90U,
  output logic      TIMER_SRC_5U5,
  output logic      TIMER_SINK_1M9,
  output logic      TIMER_SINK_2U8,
  output logic      UV_HYST_EN,
  output logic      OV_HYST_EN,
  output logic      PG_HYST_EN,
  output logic      POWER_GOOD_OUT
);

  // Retry budget: {infinite, count}
  function automatic logic [5:0] retry_budget(input logic [2:0] code);
    case (code)
      3'h0:    retry_budget = 6'h00;
      3'h1:    retry_budget = 6'h01;
      3'h2:    retry_budget = 6'h02;
      3'h3:    retry_budget = 6'h04;
      3'h4:    retry_budget = 6'h08;
      3'h5:    retry_budget = 6'h10;
      default: retry_budget = 6'h20;
    endcase
  endfunction

  logic [hsfs_pkg::NSYNC-1:0] raw;
  logic [hsfs_pkg::NSYNC-1:0] s1_q;
  logic [hsfs_pkg::NSYNC-1:0] s2_q;

  assign raw[hsfs_pkg::SY_CLSEL] = LIMIT_SELECT_PIN;
  assign raw[hsfs_pkg::SY_CBSEL] = BREAKER_SELECT_PIN;
  assign raw[hsfs_pkg::SY_RETRY] = RETRY_PIN;
  assign raw[hsfs_pkg::SY_UVEN]  = UNDERVOLT_ENABLE_PIN;
  assign raw[hsfs_pkg::SY_OV]    = OVERVOLT_PIN;
  assign raw[hsfs_pkg::SY_GOOD]  = GOOD_SENSE_IN;
  assign raw[hsfs_pkg::SY_CL25]  = SENSE_OVER_25MV;
  assign raw[hsfs_pkg::SY_CL46]  = SENSE_OVER_46MV;
  assign raw[hsfs_pkg::SY_CB18]  = BREAKER_OVER_1X8;
  assign raw[hsfs_pkg::SY_CB36]  = BREAKER_OVER_3X6;
  assign raw[hsfs_pkg::SY_PWR]   = POWER_LIMIT_CMP;
  assign raw[hsfs_pkg::SY_T17]   = TIMER_ABOVE_1V7;
  assign raw[hsfs_pkg::SY_T10]   = TIMER_ABOVE_1V0;
  assign raw[hsfs_pkg::SY_T03]   = TIMER_ABOVE_0V3;
  assign raw[hsfs_pkg::SY_SCL]   = SCL_I;
  assign raw[hsfs_pkg::SY_SDA]   = SDA_I;

  for (genvar i = 0; i < hsfs_pkg::NSYNC; i++)
  begin : g_sync
    always_ff @(posedge MCLK or negedge RST_N)
    begin
      if (!RST_N)
      begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end
      else
      begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  // Registers and flags
  logic        op_en_q, op_en_d;
  logic [7:0]  ovr_q, ovr_d;
  logic [15:0] mask_q, mask_d;
  logic        oc_q, oc_d, cb_q, cb_d, uv_q, uv_d, ov_q, ov_d;
  logic        pg_q;
  // Power state
  hsfs_pkg::hsfs_pwr_t st_q, st_d;
  logic [3:0]  cyc_q, cyc_d;
  logic [4:0]  att_q, att_d;
  logic        arm_q, arm_d;
  // Bus engine
  hsfs_pkg::hsfs_smb_t sm_q, sm_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d, cmd_q, cmd_d, lo_q, lo_d;
  logic        rw_q, rw_d, idx_q, idx_d, oe_q, oe_d, scl_p_q, sda_p_q;
  logic        wr_p, clr_p;

  logic uv_en, ov, sel_hi, cb_hi, cur_lim, brk, pwr_lim, limiting, run_ok;
  logic t17, t10, t03, scl, sda, scl_rise, scl_fall, start_c, stop_c, retry_ok;
  logic [5:0]  budget;
  logic [15:0] summary_w, diag_w, rd_w;
  logic [7:0]  input_w, vendor_w;

  assign uv_en    = s2_q[hsfs_pkg::SY_UVEN];
  assign ov       = s2_q[hsfs_pkg::SY_OV];
  assign t17      = s2_q[hsfs_pkg::SY_T17];
  assign t10      = s2_q[hsfs_pkg::SY_T10];
  assign t03      = s2_q[hsfs_pkg::SY_T03];
  assign sel_hi   = ovr_q[hsfs_pkg::OVR_CL_EN] ? ovr_q[hsfs_pkg::OVR_CL_VAL]
                                               : s2_q[hsfs_pkg::SY_CLSEL];
  assign cb_hi    = ovr_q[hsfs_pkg::OVR_CB_EN] ? ovr_q[hsfs_pkg::OVR_CB_VAL]
                                               : s2_q[hsfs_pkg::SY_CBSEL];
  assign cur_lim  = sel_hi ? s2_q[hsfs_pkg::SY_CL46] : s2_q[hsfs_pkg::SY_CL25];
  assign brk      = cb_hi ? s2_q[hsfs_pkg::SY_CB36] : s2_q[hsfs_pkg::SY_CB18];
  assign pwr_lim  = s2_q[hsfs_pkg::SY_PWR];
  assign limiting = cur_lim | pwr_lim | brk;
  assign run_ok   = uv_en & ~ov & op_en_q;
  // Retry pin high means latch; override picks a count
  assign budget   = ovr_q[hsfs_pkg::OVR_RT_EN] ? retry_budget(ovr_q[hsfs_pkg::OVR_RT_MSB:0])
                  : (s2_q[hsfs_pkg::SY_RETRY] ? 6'h00 : 6'h20);
  assign retry_ok = budget[5] | (att_q < budget[4:0]);

  // Power sequencing
  always_comb
  begin
    st_d  = st_q;
    cyc_d = cyc_q;
    att_d = att_q;
    arm_d = arm_q;
    case (st_q)
      hsfs_pkg::HS_INSERT:
        if (t17)
          st_d = hsfs_pkg::HS_OFF;
      hsfs_pkg::HS_OFF:
        if (run_ok)
        begin
          st_d  = hsfs_pkg::HS_ON;
          att_d = '0;
        end
      hsfs_pkg::HS_ON:
        if (!run_ok)
          st_d = hsfs_pkg::HS_OFF;
        else if (limiting && t17)
        begin
          if (retry_ok)
          begin
            st_d  = hsfs_pkg::HS_RETRY_DN;
            cyc_d = '0;
            att_d = att_q + 5'h01;
          end
          else
          begin
            st_d  = hsfs_pkg::HS_LATCHED;
            arm_d = 1'b0;
          end
        end
      hsfs_pkg::HS_RETRY_DN:
        if (!run_ok)
          st_d = hsfs_pkg::HS_OFF;
        else if (cyc_q == hsfs_pkg::RETRY_CYCLES)
        begin
          if (!t03)
            st_d = hsfs_pkg::HS_ON;
        end
        else if (!t10)
        begin
          cyc_d = cyc_q + 4'h1;
          st_d  = hsfs_pkg::HS_RETRY_UP;
        end
      hsfs_pkg::HS_RETRY_UP:
        if (!run_ok)
          st_d = hsfs_pkg::HS_OFF;
        else if (t17)
          st_d = hsfs_pkg::HS_RETRY_DN;
      hsfs_pkg::HS_LATCHED:
      begin
        if (!uv_en || !op_en_q)
          arm_d = 1'b1;
        // Restart only once the timer has bled below 0.3 V
        if (arm_q && uv_en && op_en_q && !t03)
          st_d = hsfs_pkg::HS_OFF;
      end
      default:
        st_d = hsfs_pkg::HS_INSERT;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q  <= hsfs_pkg::HS_INSERT;
      cyc_q <= '0;
      att_q <= '0;
      arm_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cyc_q <= cyc_d;
      att_q <= att_d;
      arm_q <= arm_d;
    end
  end

  // Status and control registers; a set always beats a clear
  always_comb
  begin
    op_en_d = op_en_q;
    ovr_d   = ovr_q;
    mask_d  = mask_q;
    oc_d    = clr_p ? 1'b0 : oc_q;
    cb_d    = clr_p ? 1'b0 : cb_q;
    uv_d    = clr_p ? 1'b0 : uv_q;
    ov_d    = clr_p ? 1'b0 : ov_q;
    if (st_q == hsfs_pkg::HS_ON && run_ok && limiting && t17)
      oc_d = 1'b1;
    if (st_q == hsfs_pkg::HS_ON && brk)
      cb_d = 1'b1;
    if (st_q != hsfs_pkg::HS_INSERT && !uv_en)
      uv_d = 1'b1;
    if (ov)
      ov_d = 1'b1;
    if (wr_p)
      case (cmd_q)
        hsfs_pkg::REG_OUTPUT_CTRL:
          if (!idx_q && sh_q == hsfs_pkg::OUT_ON_VAL)
            op_en_d = 1'b1;
          else if (!idx_q && sh_q == hsfs_pkg::OUT_OFF_VAL)
            op_en_d = 1'b0;
        hsfs_pkg::REG_HW_OVERRIDE:
          if (!idx_q)
            ovr_d = sh_q;
        hsfs_pkg::REG_ALERT_SUPPRESS:
          if (idx_q)
            mask_d = {sh_q, lo_q};
        default:
          ovr_d = ovr_q;
      endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      op_en_q <= hsfs_pkg::OUT_CTRL_RST;
      ovr_q   <= hsfs_pkg::HW_OVERRIDE_RST;
      mask_q  <= hsfs_pkg::ALERT_SUPPRESS_RST;
      oc_q    <= 1'b0;
      cb_q    <= 1'b0;
      uv_q    <= 1'b0;
      ov_q    <= 1'b0;
      pg_q    <= 1'b0;
    end
    else
    begin
      op_en_q <= op_en_d;
      ovr_q   <= ovr_d;
      mask_q  <= mask_d;
      oc_q    <= oc_d;
      cb_q    <= cb_d;
      uv_q    <= uv_d;
      ov_q    <= ov_d;
      pg_q    <= s2_q[hsfs_pkg::SY_GOOD] & uv_en & ~ov;
    end
  end

  // Read views
  always_comb
  begin
    input_w   = '0;
    vendor_w  = '0;
    summary_w = '0;
    diag_w    = '0;
    input_w[hsfs_pkg::IN_HIGH_BIT]     = ov_q;
    input_w[hsfs_pkg::IN_LOW_BIT]      = uv_q;
    input_w[hsfs_pkg::IN_OC_BIT]       = oc_q;
    vendor_w[hsfs_pkg::VEN_CB_BIT]     = cb_q;
    summary_w[hsfs_pkg::SUM_INPUT_BIT] = oc_q | uv_q | ov_q;
    summary_w[hsfs_pkg::SUM_PG_N_BIT]  = ~pg_q;
    diag_w[hsfs_pkg::DG_OCOP_BIT]      = oc_q;
    diag_w[hsfs_pkg::DG_UV_BIT]        = uv_q;
    diag_w[hsfs_pkg::DG_OV_BIT]        = ov_q;
    diag_w[hsfs_pkg::DG_CB_BIT]        = cb_q;
    diag_w[hsfs_pkg::DG_LATCH_BIT]     = (st_q == hsfs_pkg::HS_LATCHED);
    diag_w[hsfs_pkg::DG_PG_BIT]        = pg_q;
    case (cmd_q)
      hsfs_pkg::REG_OUTPUT_CTRL:    rd_w = op_en_q ? {8'h00, hsfs_pkg::OUT_ON_VAL} : 16'h0000;
      hsfs_pkg::REG_SUMMARY_STATUS: rd_w = summary_w;
      hsfs_pkg::REG_INPUT_STATUS:   rd_w = {8'h00, input_w};
      hsfs_pkg::REG_VENDOR_STATUS:  rd_w = {8'h00, vendor_w};
      hsfs_pkg::REG_ALERT_SUPPRESS: rd_w = mask_q;
      hsfs_pkg::REG_HW_OVERRIDE:    rd_w = {8'h00, ovr_q};
      hsfs_pkg::REG_DIAG_SUMMARY:   rd_w = diag_w;
      default:                      rd_w = 16'h0000;
    endcase
  end

  // Bus engine; no clock stretching, so MCLK must be well above SCL
  assign scl      = s2_q[hsfs_pkg::SY_SCL];
  assign sda      = s2_q[hsfs_pkg::SY_SDA];
  assign scl_rise = scl & ~scl_p_q;
  assign scl_fall = ~scl & scl_p_q;
  assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;

  always_comb
  begin
    sm_d  = sm_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    cmd_d = cmd_q;
    lo_d  = lo_q;
    rw_d  = rw_q;
    idx_d = idx_q;
    oe_d  = oe_q;
    wr_p  = 1'b0;
    clr_p = 1'b0;
    if (start_c)
    begin
      sm_d  = hsfs_pkg::SB_ADDR;
      bit_d = '0;
      oe_d  = 1'b0;
    end
    else if (stop_c)
    begin
      sm_d = hsfs_pkg::SB_IDLE;
      oe_d = 1'b0;
    end
    else
      case (sm_q)
        hsfs_pkg::SB_ADDR, hsfs_pkg::SB_CMD, hsfs_pkg::SB_WDAT:
          if (scl_rise && bit_q != hsfs_pkg::BYTE_BITS)
          begin
            sh_d  = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == hsfs_pkg::BYTE_BITS)
          begin
            bit_d = '0;
            oe_d  = 1'b1;
            if (sm_q == hsfs_pkg::SB_ADDR)
            begin
              rw_d  = sh_q[0];
              idx_d = 1'b0;
              sm_d  = hsfs_pkg::SB_AACK;
              if (sh_q[7:1] != DEV_ADDR)
              begin
                sm_d = hsfs_pkg::SB_IDLE;
                oe_d = 1'b0;
              end
            end
            else if (sm_q == hsfs_pkg::SB_CMD)
            begin
              cmd_d = sh_q;
              sm_d  = hsfs_pkg::SB_CACK;
              clr_p = (sh_q == hsfs_pkg::REG_CLEAR_FLAGS);
            end
            else
            begin
              wr_p = 1'b1;
              lo_d = sh_q;
              sm_d = hsfs_pkg::SB_WACK;
            end
          end
        hsfs_pkg::SB_AACK:
          if (scl_fall)
          begin
            sm_d = rw_q ? hsfs_pkg::SB_RDAT : hsfs_pkg::SB_CMD;
            sh_d = rd_w[7:0];
            oe_d = rw_q & ~rd_w[7];
          end
        hsfs_pkg::SB_CACK, hsfs_pkg::SB_WACK:
          if (scl_fall)
          begin
            idx_d = (sm_q == hsfs_pkg::SB_WACK);
            sm_d  = hsfs_pkg::SB_WDAT;
            oe_d  = 1'b0;
          end
        hsfs_pkg::SB_RDAT:
          if (scl_rise)
            bit_d = bit_q + 4'h1;
          else if (scl_fall && bit_q == hsfs_pkg::BYTE_BITS)
          begin
            sm_d  = hsfs_pkg::SB_RACK;
            bit_d = '0;
            oe_d  = 1'b0;
          end
          else if (scl_fall)
          begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        hsfs_pkg::SB_RACK:
          if (scl_rise)
            rw_d = ~sda;
          else if (scl_fall && rw_q)
          begin
            idx_d = 1'b1;
            sm_d  = hsfs_pkg::SB_RDAT;
            sh_d  = rd_w[15:8];
            oe_d  = ~rd_w[15];
          end
          else if (scl_fall)
            sm_d = hsfs_pkg::SB_IDLE;
        default:
          sm_d = hsfs_pkg::SB_IDLE;
      endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sm_q    <= hsfs_pkg::SB_IDLE;
      bit_q   <= '0;
      sh_q    <= '0;
      cmd_q   <= '0;
      lo_q    <= '0;
      rw_q    <= 1'b0;
      idx_q   <= 1'b0;
      oe_q    <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      sm_q    <= sm_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      cmd_q   <= cmd_d;
      lo_q    <= lo_d;
      rw_q    <= rw_d;
      idx_q   <= idx_d;
      oe_q    <= oe_d;
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  // Pin drive
  assign SDA_O          = 1'b0;
  assign SDA_OE         = oe_q;
  assign SMBA_O         = 1'b0;
  assign SMBA_OE        = |(diag_w & hsfs_pkg::DG_ALERT_SRC & ~mask_q);
  assign GATE_STRONG_PD = (st_q == hsfs_pkg::HS_ON) & brk;
  assign GATE_CHARGE    = (st_q == hsfs_pkg::HS_ON) & ~brk;
  assign GATE_REGULATE  = (st_q == hsfs_pkg::HS_ON) & (cur_lim | pwr_lim);
  assign GATE_PD_2MA    = (st_q != hsfs_pkg::HS_ON);
  assign TIMER_SRC_90U  = ((st_q == hsfs_pkg::HS_ON) & limiting)
                        | (st_q == hsfs_pkg::HS_RETRY_UP);
  assign TIMER_SRC_5U5  = (st_q == hsfs_pkg::HS_INSERT);
  assign TIMER_SINK_1M9 = ((st_q == hsfs_pkg::HS_ON) & ~limiting)
                        | (st_q == hsfs_pkg::HS_OFF);
  assign TIMER_SINK_2U8 = (st_q == hsfs_pkg::HS_LATCHED) | (st_q == hsfs_pkg::HS_RETRY_DN);
  assign UV_HYST_EN     = ~uv_en;
  assign OV_HYST_EN     = ov;
  assign PG_HYST_EN     = s2_q[hsfs_pkg::SY_GOOD];
  assign POWER_GOOD_OUT = pg_q;

  default clocking dclk @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_timeout;
    st_q == hsfs_pkg::HS_ON && run_ok && limiting && t17;
  endsequence
  sequence s_last_ramp;
    st_q == hsfs_pkg::HS_RETRY_DN && run_ok && cyc_q == hsfs_pkg::RETRY_CYCLES && !t03;
  endsequence

  breaker_pull_a: assert property ((st_q == hsfs_pkg::HS_ON && brk)
    |-> GATE_STRONG_PD && !GATE_CHARGE) else $error("breaker pull-down missing");
  breaker_release_a: assert property ((st_q == hsfs_pkg::HS_ON && !brk)
    |-> !GATE_STRONG_PD && GATE_CHARGE) else $error("strong pull-down not released");
  timer_charge_a: assert property ((st_q == hsfs_pkg::HS_ON && limiting)
    |-> TIMER_SRC_90U && !TIMER_SINK_1M9) else $error("timer source wrong");
  fault_off_a: assert property (s_timeout
    |=> GATE_PD_2MA && !GATE_CHARGE && oc_q) else $error("timeout did not turn gate off");
  latch_flag_a: assert property ((st_q == hsfs_pkg::HS_LATCHED)
    == (diag_w[hsfs_pkg::DG_LATCH_BIT] && GATE_PD_2MA && TIMER_SINK_2U8 && !TIMER_SRC_90U))
    else $error("latched bit mismatch");
  restart_a: assert property (s_last_ramp
    |=> st_q == hsfs_pkg::HS_ON ##1 GATE_CHARGE || GATE_STRONG_PD) else $error("no restart");
  pg_force_a: assert property ((!uv_en || ov) |=> !POWER_GOOD_OUT)
    else $error("power good not forced low");
  uv_gate_a: assert property ((!uv_en && st_q != hsfs_pkg::HS_INSERT)
    |=> GATE_PD_2MA && uv_q) else $error("undervoltage not handled");
  alert_a: assert property (SMBA_OE == ((oc_q && !mask_q[hsfs_pkg::DG_OCOP_BIT])
    || (uv_q && !mask_q[hsfs_pkg::DG_UV_BIT]) || (ov_q && !mask_q[hsfs_pkg::DG_OV_BIT])
    || (cb_q && !mask_q[hsfs_pkg::DG_CB_BIT]))) else $error("alert level wrong");

endmodule

`default_nettype wire

// File: hw/hsfs_pkg.sv
// Constants, register map and state types of the hot-swap fault supervisor
package hsfs_pkg;

  // Command codes on the management port
  localparam logic [7:0] REG_OUTPUT_CTRL    = 8'h03;
  localparam logic [7:0] REG_CLEAR_FLAGS    = 8'h05;
  localparam logic [7:0] REG_SUMMARY_STATUS = 8'h79;
  localparam logic [7:0] REG_INPUT_STATUS   = 8'h7C;
  localparam logic [7:0] REG_VENDOR_STATUS  = 8'h80;
  localparam logic [7:0] REG_ALERT_SUPPRESS = 8'hD8;
  localparam logic [7:0] REG_HW_OVERRIDE    = 8'hD9;
  localparam logic [7:0] REG_DIAG_SUMMARY   = 8'hE1;

  localparam logic [7:0]  OUT_ON_VAL         = 8'h80;
  localparam logic [7:0]  OUT_OFF_VAL        = 8'h00;
  localparam logic        OUT_CTRL_RST       = 1'b1;
  localparam logic [15:0] ALERT_SUPPRESS_RST = 16'h0000;
  localparam logic [7:0]  HW_OVERRIDE_RST    = 8'h00;

  // Status field positions
  localparam int IN_HIGH_BIT   = 7;
  localparam int IN_LOW_BIT    = 4;
  localparam int IN_OC_BIT     = 1;
  localparam int SUM_INPUT_BIT = 13;
  localparam int SUM_PG_N_BIT  = 11;
  localparam int VEN_CB_BIT    = 6;
  localparam int DG_OCOP_BIT   = 14;
  localparam int DG_UV_BIT     = 13;
  localparam int DG_OV_BIT     = 12;
  localparam int DG_CB_BIT     = 9;
  localparam int DG_LATCH_BIT  = 8;
  localparam int DG_PG_BIT     = 3;
  localparam logic [15:0] DG_ALERT_SRC = (16'h0001 << DG_OCOP_BIT) | (16'h0001 << DG_UV_BIT)
                                       | (16'h0001 << DG_OV_BIT) | (16'h0001 << DG_CB_BIT);

  // Override register fields
  localparam int OVR_CL_EN  = 7;
  localparam int OVR_CL_VAL = 6;
  localparam int OVR_CB_EN  = 5;
  localparam int OVR_CB_VAL = 4;
  localparam int OVR_RT_EN  = 3;
  localparam int OVR_RT_MSB = 2;

  localparam logic [3:0] RETRY_CYCLES = 4'h7;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // Synchroniser slots
  localparam int SY_CLSEL = 0;
  localparam int SY_CBSEL = 1;
  localparam int SY_RETRY = 2;
  localparam int SY_UVEN  = 3;
  localparam int SY_OV    = 4;
  localparam int SY_GOOD  = 5;
  localparam int SY_CL25  = 6;
  localparam int SY_CL46  = 7;
  localparam int SY_CB18  = 8;
  localparam int SY_CB36  = 9;
  localparam int SY_PWR   = 10;
  localparam int SY_T17   = 11;
  localparam int SY_T10   = 12;
  localparam int SY_T03   = 13;
  localparam int SY_SCL   = 14;
  localparam int SY_SDA   = 15;
  localparam int NSYNC    = 16;

  typedef enum logic [2:0] {
    HS_INSERT   = 3'h0,
    HS_OFF      = 3'h1,
    HS_ON       = 3'h3,
    HS_RETRY_DN = 3'h2,
    HS_RETRY_UP = 3'h6,
    HS_LATCHED  = 3'h7
  } hsfs_pwr_t;

  typedef enum logic [3:0] {
    SB_IDLE = 4'h0,
    SB_ADDR = 4'h1,
    SB_AACK = 4'h3,
    SB_CMD  = 4'h2,
    SB_CACK = 4'h6,
    SB_WDAT = 4'h7,
    SB_WACK = 4'h5,
    SB_RDAT = 4'h4,
    SB_RACK = 4'hC
  } hsfs_smb_t;

endpackage

// File: dv/hsfs_host.sv
// Host model driving the two-wire status port
`timescale 1ns/1ps
`default_nettype none
module hsfs_host #(
  parameter logic [6:0] ADDR = 7'h40
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Six clocks a phase keeps well clear of the four-clock floor
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    hw(6);
    scl <= 1'b1;
    hw(4);
    s = sda_in;
    hw(2);
    scl <= 1'b0;
    hw(1);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, ak);
    ak = ~ak;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    hw(6);
    scl <= 1'b1;
    hw(6);
    sda_low <= 1'b1;
    hw(6);
    scl <= 1'b0;
    hw(1);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hw(6);
    scl <= 1'b1;
    hw(6);
    sda_low <= 1'b0;
    hw(6);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, output logic ak);
    logic [7:0] q;
    logic a;
    start();
    xfer({ADDR, 1'b0}, q, ak);
    xfer(c, q, a);
    for (int i = 0; i < n; i++)
      xfer(d[8*i+:8], q, a);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [7:0] q;
    logic a;
    start();
    xfer({ADDR, 1'b0}, q, a);
    xfer(c, q, a);
    start();
    xfer({ADDR, 1'b1}, q, a);
    for (int i = 0; i < 8; i++)
      bit_io(1'b1, v[7-i]);
    bit_io(1'b0, a);
    xfer(8'hFF, v[15:8], a);
    stop();
  endtask
endmodule
`default_nettype wire

// File: dv/hsfs_top_tb.sv
// Self-checking bench of the hot-swap fault supervisor
`timescale 1ns/1ps
`default_nettype none
module hsfs_top_tb;
  logic MCLK = 0, RST_N = 0, LIMIT_SELECT_PIN = 0, BREAKER_SELECT_PIN = 0, RETRY_PIN = 1;
  logic UNDERVOLT_ENABLE_PIN = 1, OVERVOLT_PIN = 0, GOOD_SENSE_IN = 0, SENSE_OVER_25MV = 0;
  logic SENSE_OVER_46MV = 0, BREAKER_OVER_1X8 = 0, BREAKER_OVER_3X6 = 0, POWER_LIMIT_CMP = 0;
  logic TIMER_ABOVE_1V7 = 0, TIMER_ABOVE_1V0 = 0, TIMER_ABOVE_0V3 = 0, ak, sl, a, b;
  wire logic SCL_I, SDA_I, SDA_O, SDA_OE, SMBA_O, SMBA_OE, GATE_STRONG_PD, GATE_PD_2MA;
  wire logic GATE_CHARGE, GATE_REGULATE, TIMER_SRC_90U, TIMER_SRC_5U5, TIMER_SINK_1M9;
  wire logic TIMER_SINK_2U8, UV_HYST_EN, OV_HYST_EN, PG_HYST_EN, POWER_GOOD_OUT, sda_low;
  int num_errors = 0, num_checks = 0, seed = 23281, cyc = 0;
  logic [15:0] v;
  always #25 MCLK = ~MCLK;
  // Open-drain data line with pull-up
  assign SDA_I = ~(sda_low | (SDA_OE & ~SDA_O));
  hsfs_top hsfs_top_i (.*);
  hsfs_host hsfs_host_i (.clk(MCLK), .sda_in(SDA_I), .scl(SCL_I), .sda_low(sda_low));
  function automatic logic lim(input logic s, input logic c25, input logic c46);
    return s ? c46 : c25;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    w(12);
    RST_N <= 1;
    w(3);
    chk("ins", {GATE_PD_2MA, TIMER_SRC_5U5, POWER_GOOD_OUT}, 3'b110);
    chk("idle", {SDA_O, SDA_OE, SMBA_O, SMBA_OE}, 4'h0);
    TIMER_ABOVE_1V7 <= 1;
    w(6);
    TIMER_ABOVE_1V7 <= 0;
    w(6);
    chk("on", {GATE_PD_2MA, GATE_CHARGE, UV_HYST_EN}, 3'b010);
    $display("insertion done");
    for (int i = 0; i < 10; i++)
    begin
      sl = $random(seed);
      a = $random(seed);
      b = a & $random(seed);
      LIMIT_SELECT_PIN <= sl;
      SENSE_OVER_25MV <= a;
      SENSE_OVER_46MV <= b;
      w(6);
      chk("lim", {GATE_REGULATE, TIMER_SRC_90U}, {2{lim(sl, a, b)}});
    end
    SENSE_OVER_46MV <= 0;
    LIMIT_SELECT_PIN <= 0;
    hsfs_host_i.wr(8'hD9, 16'h00C0, 1, ak);
    chk("ack", ak, 1'b1);
    SENSE_OVER_25MV <= 1;
    w(6);
    chk("ovr", GATE_REGULATE, 1'b0);
    hsfs_host_i.wr(8'hD9, 16'h0000, 1, ak);
    SENSE_OVER_25MV <= 0;
    w(6);
    chk("clr", {TIMER_SRC_90U, TIMER_SINK_1M9, GATE_PD_2MA}, 3'b010);
    $display("limit done");
    POWER_LIMIT_CMP <= 1;
    BREAKER_OVER_1X8 <= 1;
    w(6);
    chk("cb", {GATE_STRONG_PD, TIMER_SRC_90U}, 2'b11);
    BREAKER_OVER_1X8 <= 0;
    w(6);
    chk("cbr", {GATE_STRONG_PD, GATE_REGULATE, SMBA_OE}, 3'b011);
    hsfs_host_i.rd(8'h80, v);
    chk("vs", v[6], 1'b1);
    TIMER_ABOVE_1V7 <= 1;
    w(6);
    POWER_LIMIT_CMP <= 0;
    TIMER_ABOVE_1V7 <= 0;
    w(6);
    chk("to", {GATE_PD_2MA, GATE_CHARGE, TIMER_SINK_2U8}, 3'b101);
    hsfs_host_i.rd(8'h7C, v);
    chk("is", v[1], 1'b1);
    hsfs_host_i.rd(8'hE1, v);
    chk("dg", {v[14], v[9], v[8]}, 3'b111);
    hsfs_host_i.rd(8'h79, v);
    chk("sw", v[13], 1'b1);
    UNDERVOLT_ENABLE_PIN <= 0;
    w(6);
    UNDERVOLT_ENABLE_PIN <= 1;
    w(8);
    chk("rs", GATE_PD_2MA, 1'b0);
    hsfs_host_i.rd(8'hE1, v);
    chk("lt", v[8], 1'b0);
    $display("timeout done");
    hsfs_host_i.wr(8'h05, 16'h0000, 0, ak);
    hsfs_host_i.wr(8'h03, 16'h0000, 1, ak);
    w(4);
    chk("off", GATE_PD_2MA, 1'b1);
    hsfs_host_i.wr(8'h03, 16'h0080, 1, ak);
    w(4);
    chk("rearm", {GATE_PD_2MA, SMBA_OE}, 2'b00);
    UNDERVOLT_ENABLE_PIN <= 0;
    w(6);
    chk("uv", {UV_HYST_EN, GATE_PD_2MA, SMBA_OE}, 3'b111);
    hsfs_host_i.rd(8'h7C, v);
    chk("uvf", v[4], 1'b1);
    UNDERVOLT_ENABLE_PIN <= 1;
    GOOD_SENSE_IN <= 1;
    w(8);
    chk("pg", {POWER_GOOD_OUT, PG_HYST_EN}, 2'b11);
    hsfs_host_i.rd(8'hE1, v);
    chk("pgs", v[3], 1'b1);
    hsfs_host_i.wr(8'h05, 16'h0000, 0, ak);
    hsfs_host_i.wr(8'hD8, 16'h1000, 2, ak);
    OVERVOLT_PIN <= 1;
    w(6);
    chk("ov", {POWER_GOOD_OUT, GATE_PD_2MA, OV_HYST_EN, SMBA_OE}, 4'b0110);
    hsfs_host_i.rd(8'h7C, v);
    chk("ovf", v[7], 1'b1);
    OVERVOLT_PIN <= 0;
    w(8);
    chk("ovc", {POWER_GOOD_OUT, GATE_PD_2MA}, 2'b10);
    $display("lockout done");
    // One retry allowed by override: full restart ramp, then latch on the next timeout
    hsfs_host_i.wr(8'hD9, 16'h0009, 1, ak);
    POWER_LIMIT_CMP <= 1;
    TIMER_ABOVE_0V3 <= 1;
    TIMER_ABOVE_1V0 <= 1;
    TIMER_ABOVE_1V7 <= 1;
    w(6);
    chk("rt", {GATE_PD_2MA, TIMER_SINK_2U8, TIMER_SRC_90U}, 3'b110);
    for (int i = 0; i < 7; i++)
    begin
      TIMER_ABOVE_1V7 <= 0;
      TIMER_ABOVE_1V0 <= 0;
      w(6);
      chk("up", {GATE_PD_2MA, TIMER_SRC_90U, TIMER_SINK_2U8}, 3'b110);
      TIMER_ABOVE_1V7 <= 1;
      TIMER_ABOVE_1V0 <= 1;
      w(6);
    end
    TIMER_ABOVE_1V7 <= 0;
    TIMER_ABOVE_1V0 <= 0;
    w(6);
    chk("dn8", {GATE_PD_2MA, TIMER_SINK_2U8}, 2'b11);
    TIMER_ABOVE_0V3 <= 0;
    w(6);
    chk("re", {GATE_PD_2MA, GATE_REGULATE, TIMER_SRC_90U}, 3'b011);
    TIMER_ABOVE_1V7 <= 1;
    w(6);
    chk("lat", {GATE_PD_2MA, TIMER_SINK_2U8, GATE_CHARGE}, 3'b110);
    hsfs_host_i.rd(8'hE1, v);
    chk("lt2", v[8], 1'b1);
    $display("retry done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
